// ---- verilog/cdgc_pkg.sv ----
// Package for the card-detect and global control register block
package cdgc_pkg;
	localparam logic [11:0] CDGC_OFF_DETECT = 12'h816;
	localparam logic [11:0] CDGC_OFF_GLOBAL = 12'h81E;
	localparam logic [11:0] CDGC_OFF_CHANGE = 12'h804;
	localparam logic [11:0] CDGC_OFF_CHGCFG = 12'h805;
	localparam int CDGC_B_SENSE2 = 7;
	localparam int CDGC_B_SENSE1 = 6;
	localparam int CDGC_B_SOFT = 5;
	localparam int CDGC_B_WAKE = 4;
	localparam int CDGC_B_REMOVAL = 1;
	localparam int CDGC_B_STYLE_B = 4;
	localparam int CDGC_B_STYLE_A = 3;
	localparam int CDGC_B_CLEAR = 2;
	localparam int CDGC_B_CHG_STYLE = 1;
	localparam int CDGC_B_SLEEP = 0;
	localparam int CDGC_B_DET_IRQ_EN = 3;
	localparam int CDGC_B_STATUS_CHANGE = 0;
	localparam logic [7:0] CDGC_GLOBAL_RST = 8'h00;
	localparam logic [7:0] CDGC_GLOBAL_MASK = 8'h1F;
	localparam logic [7:0] CDGC_DETECT_WMASK = 8'h12;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} cdgc_req_t;

	typedef struct packed {
		logic cd1_n;
		logic cd2_n;
		logic sense1;
		logic sense2;
		logic func_irq;
	} cdgc_card_t;
endpackage : cdgc_pkg

// ---- verilog/cdgc_top.sv ----
// Card-detect control and shared global control registers for one socket
//
// Functional notes
// - Bit 7 reads live second sense pin
// - Bit 6 reads live first sense pin
// - Soft detect write raises change when enabled
// - Soft detect write ignored when disabled
// - Soft detect bit always reads zero
// - Wake enable: detect change drives ring low
// - Ring stays low until change flag cleared
// - Bit 1 resets socket registers on removal
// - Detect bits 3, 2, 0 read zero
// - Global register single, shared by sockets
// - Global bits 7 to 5 read zero
// - Global bit 4: card B irq style
// - Global bit 3: card A irq style
// - Global bit 2: flag clear by read or write
// - Global bit 1: change irq style
// - Sleep bit floats card outputs until access
// - Outputs float again after each access
// - Interrupts still accepted while sleeping
`timescale 1ns/1ps
`default_nettype none
module cdgc_top
	import cdgc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire cdgc_pkg::cdgc_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Card side
	input wire cdgc_pkg::cdgc_card_t card,
	input wire logic card_cycle_active,
	output logic card_out_en,
	// Shared global register, driven by socket A instance
	input wire logic [7:0] global_in,
	input wire logic is_global_owner,
	output logic [7:0] global_out,
	// Host side
	output logic ring_wake_output,
	output logic change_irq,
	output logic func_irq_out,
	output logic socket_regs_reset
);
	import cdgc_pkg::*;

	logic detect_wake_enable_q;
	logic reset_on_removal_q;

	logic [7:0] global_q;
	logic [7:0] global_d;
	logic [7:0] chg_cfg_q;
	logic [7:0] chg_cfg_d;
	logic [7:0] status_change_q;
	logic [7:0] status_change_d;

	logic [1:0] cd_q;
	logic func_q;
	logic change_lvl_q;

	logic ring_wake_q;
	logic ring_wake_d;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic out_en_q;
	logic out_en_d;
	logic change_irq_q;
	logic func_irq_q;
	logic removal_q;

	logic [7:0] glob;
	logic wr_detect;
	logic wr_global;
	logic wr_chgcfg;
	logic wr_change;
	logic rd_change;

	logic [1:0] cd_now;
	logic det_irq_en;
	logic soft_evt;
	logic cd_evt;
	logic removed;
	logic removal_evt;
	logic func_style;
	logic [7:0] chg_set;
	logic [7:0] chg_clr;
	logic any_change;
	logic [7:0] read_word;

	function automatic logic hit(input cdgc_req_t r, input logic [11:0] off);
		hit = r.addr == off;
	endfunction : hit

	function automatic logic irq_style(input logic lvl_mode, input logic now,
		input logic prev);
		if (lvl_mode) begin
			irq_style = now;
		end else begin
			irq_style = now & ~prev;
		end
	endfunction : irq_style

	function automatic logic [7:0] detect_view(input logic s2, input logic s1,
		input logic wake, input logic rem);
		detect_view = 8'h00;
		detect_view[CDGC_B_SENSE2] = s2;
		detect_view[CDGC_B_SENSE1] = s1;
		detect_view[CDGC_B_SOFT] = 1'b0;
		detect_view[CDGC_B_WAKE] = wake;
		detect_view[CDGC_B_REMOVAL] = rem;
	endfunction : detect_view

	function automatic logic [7:0] clear_mask(input logic by_write, input logic wr_hit,
		input logic rd_hit, input logic [7:0] data);
		if (by_write) begin
			clear_mask = wr_hit ? data : 8'h00;
		end else begin
			clear_mask = rd_hit ? 8'hFF : 8'h00;
		end
	endfunction : clear_mask

	// One global copy; non-owner sockets use the owner's value
	assign glob = is_global_owner ? global_q : global_in;
	assign wr_detect = req.wr & hit(req, CDGC_OFF_DETECT);
	assign wr_global = req.wr & hit(req, CDGC_OFF_GLOBAL) & is_global_owner;
	assign wr_chgcfg = req.wr & hit(req, CDGC_OFF_CHGCFG);
	assign wr_change = req.wr & hit(req, CDGC_OFF_CHANGE);
	assign rd_change = req.rd & hit(req, CDGC_OFF_CHANGE);
	assign det_irq_en = chg_cfg_q[CDGC_B_DET_IRQ_EN];
	assign cd_now = {card.cd2_n, card.cd1_n};

	assign soft_evt = wr_detect & req.wdata[CDGC_B_SOFT] & det_irq_en;
	assign cd_evt = cd_q != cd_now;
	assign removed = cd_evt & (|cd_now);
	assign removal_evt = removed & reset_on_removal_q;
	assign chg_set = {7'h00, soft_evt | (cd_evt & det_irq_en)};
	assign chg_clr = clear_mask(glob[CDGC_B_CLEAR], wr_change, rd_change,
		req.wdata);
	assign any_change = |status_change_q;
	assign func_style = is_global_owner ? glob[CDGC_B_STYLE_A]
		: glob[CDGC_B_STYLE_B];

	// Detect control register fields
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			detect_wake_enable_q <= 1'b0;
		end else if (wr_detect) begin
			detect_wake_enable_q <= req.wdata[CDGC_B_WAKE];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_on_removal_q <= 1'b0;
		end else if (wr_detect) begin
			reset_on_removal_q <= req.wdata[CDGC_B_REMOVAL];
		end
	end

	// Shared global register
	always_comb begin
		global_d = global_q;
		if (wr_global) begin
			global_d = req.wdata & CDGC_GLOBAL_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			global_q <= CDGC_GLOBAL_RST;
		end else begin
			global_q <= global_d;
		end
	end

	// Status-change interrupt configuration copy
	always_comb begin
		chg_cfg_d = chg_cfg_q;
		if (wr_chgcfg) begin
			chg_cfg_d = req.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_cfg_q <= 8'h00;
		end else begin
			chg_cfg_q <= chg_cfg_d;
		end
	end

	// Status-change flags; set wins over clear
	always_comb begin
		if (removal_evt) begin
			status_change_d = chg_set;
		end else begin
			status_change_d = (status_change_q & ~chg_clr) | chg_set;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_change_q <= 8'h00;
		end else begin
			status_change_q <= status_change_d;
		end
	end

	// Card-detect history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cd_q <= 2'b11;
		end else begin
			cd_q <= cd_now;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func_q <= 1'b0;
		end else begin
			func_q <= card.func_irq;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			change_lvl_q <= 1'b0;
		end else begin
			change_lvl_q <= any_change;
		end
	end

	// Ring wake output, low until change flag clears
	always_comb begin
		ring_wake_d = ring_wake_q;
		if (detect_wake_enable_q & cd_evt) begin
			ring_wake_d = 1'b0;
		end else if (!status_change_q[CDGC_B_STATUS_CHANGE]) begin
			ring_wake_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ring_wake_q <= 1'b1;
		end else begin
			ring_wake_q <= ring_wake_d;
		end
	end

	// Removal reset pulse for socket registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			removal_q <= 1'b0;
		end else begin
			removal_q <= removal_evt;
		end
	end

	// Host interrupts, edge or level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			change_irq_q <= 1'b0;
		end else begin
			change_irq_q <= irq_style(glob[CDGC_B_CHG_STYLE], any_change,
				change_lvl_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func_irq_q <= 1'b0;
		end else begin
			func_irq_q <= irq_style(func_style, card.func_irq,
				func_q);
		end
	end

	// Card output enable under sleep mode
	always_comb begin
		out_en_d = 1'b1;
		if (glob[CDGC_B_SLEEP]) begin
			out_en_d = card_cycle_active;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_en_q <= 1'b1;
		end else begin
			out_en_q <= out_en_d;
		end
	end

	// Register read mux
	always_comb begin
		read_word = 8'h00;
		if (hit(req, CDGC_OFF_DETECT)) begin
			read_word = detect_view(card.sense2, card.sense1, detect_wake_enable_q,
				reset_on_removal_q);
		end else if (hit(req, CDGC_OFF_GLOBAL)) begin
			read_word = glob & CDGC_GLOBAL_MASK;
		end else if (hit(req, CDGC_OFF_CHANGE)) begin
			read_word = status_change_q;
		end else if (hit(req, CDGC_OFF_CHGCFG)) begin
			read_word = chg_cfg_q;
		end
	end

	// Read strobe echo
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
		end
	end

	// Read data, zero outside a read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			rdata_q <= read_word;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;

	assign card_out_en = out_en_q;
	assign global_out = global_q;

	assign ring_wake_output = ring_wake_q;
	assign change_irq = change_irq_q;
	assign func_irq_out = func_irq_q;
	assign socket_regs_reset = removal_q;
endmodule : cdgc_top
`default_nettype wire

// ---- test/cdgc_card_model.sv ----
// Card in the socket: detect, sense and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module cdgc_card_model
	import cdgc_pkg::*;
(
	// Card stimulus and pins
	input wire logic inserted,
	input wire logic irq,
	output var cdgc_pkg::cdgc_card_t card
);
	assign card = {!inserted, !inserted, 1'b0, inserted, irq};
endmodule : cdgc_card_model
`default_nettype wire

// ---- test/cdgc_top_assertions.sv ----
// Port checker for the detect and global control block
`timescale 1ns/1ps
`default_nettype none
module cdgc_top_assertions
	import cdgc_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic rst_n,
	input wire cdgc_pkg::cdgc_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire cdgc_pkg::cdgc_card_t card,
	input wire logic card_cycle_active,
	input wire logic card_out_en,
	input wire logic [7:0] global_in,
	input wire logic is_global_owner,
	input wire logic [7:0] global_out,
	input wire logic ring_wake_output,
	input wire logic change_irq,
	input wire logic func_irq_out,
	input wire logic socket_regs_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_detect_read: assert property (
		$past(req.rd) && $past(req.addr) == CDGC_OFF_DETECT |->
		{rdata[7:5], rdata[3:2], rdata[0]} == {$past({card.sense2, card.sense1}), 4'h0})
		else $error("detect read");
	a_global_rsvd: assert property (global_out[7:5] == 3'h0) else $error("global rsvd");
	a_ring_held: assert property (!ring_wake_output && !req.rd && !req.wr &&
		!$past(req.rd) && !$past(req.wr) && !socket_regs_reset |=> !ring_wake_output)
		else $error("ring rise");
	a_sleep_float: assert property (global_out[0] && $past(global_out[0]) &&
		!$past(card_cycle_active) |-> !card_out_en) else $error("sleep drive");
	a_active_wake: assert property (global_out[0] && card_cycle_active |=> card_out_en)
		else $error("no wake");
	a_awake_drive: assert property (!global_out[0] && !$past(global_out[0]) |-> card_out_en)
		else $error("awake float");
	a_edge_once: assert property (change_irq && !global_out[1] &&
		!$past(global_out[1]) |=> !change_irq) else $error("edge long");
	a_removal_pulse: assert property (socket_regs_reset |=> !socket_regs_reset)
		else $error("reset long");
endmodule : cdgc_top_assertions
bind cdgc_top cdgc_top_assertions i_cdgc_top_assertions (.*);
`default_nettype wire

// ---- test/card_detect_global_control_tb.sv ----
// Bench for the detect and global control block
`timescale 1ns/1ps
`default_nettype none
module card_detect_global_control_tb;
	import cdgc_pkg::*;
	typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e;} cdgc_row_t;
	logic clk, rst_n, act, ins, irq, ring, chg, fo, srr, rv, oe;
	logic [7:0] rd, go, v;
	cdgc_req_t req;
	cdgc_card_t card;
	int err_total, check_count, cyc, n, m;
	cdgc_row_t rows[4] = '{'{CDGC_OFF_GLOBAL, 8'hFF, 8'h1F}, '{CDGC_OFF_DETECT, 8'hFF, 8'h92},
		'{12'h800, 8'hAA, 8'h00}, '{CDGC_OFF_GLOBAL, 8'h00, 8'h00}};
	cdgc_top i_cdgc_top (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rd), .rvalid(rv),
		.card(card), .card_cycle_active(act), .card_out_en(oe), .global_in(8'h00),
		.is_global_owner(1'b1), .global_out(go), .ring_wake_output(ring), .change_irq(chg),
		.func_irq_out(fo), .socket_regs_reset(srr));
	cdgc_card_model i_cdgc_card_model (.inserted(ins), .irq(irq), .card(card));
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task chk(input logic [7:0] s, input logic [7:0] e, input string nm);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b0, 1'b1, a, d};
		@(posedge clk) req <= '0;
	endtask : wr
	task rdr(input logic [11:0] a);
		@(posedge clk) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk) req <= '0;
		#1 v = rd;
		chk({7'h0, rv}, 8'h01, "rvalid");
	endtask : rdr
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		n <= n + int'(chg);
		m <= m + int'(srr);
		if (cyc == 2000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		{rst_n, act, irq, ins, req} = '0;
		ins <= 1'b1;
		repeat (6) @(posedge clk);
		chk({ring, oe, chg, srr, fo, go[2:0]}, 8'hC0, "reset");
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rdr(rows[i].a);
			chk(v, rows[i].e, "row");
		end
		$display("rows done");
		wr(CDGC_OFF_DETECT, 8'h20);
		rdr(CDGC_OFF_CHANGE);
		chk(v, 8'h00, "soft off");
		wr(CDGC_OFF_CHGCFG, 8'h08);
		wr(CDGC_OFF_DETECT, 8'h20);
		repeat (3) @(posedge clk);
		#1 chk(8'(n), 8'h01, "pulse");
		rdr(CDGC_OFF_CHANGE);
		chk(v, 8'h01, "flag");
		rdr(CDGC_OFF_CHANGE);
		chk(v, 8'h00, "rd clear");
		$display("soft done");
		wr(CDGC_OFF_DETECT, 8'h10);
		@(posedge clk) ins <= 1'b0;
		repeat (8) @(posedge clk);
		#1 chk({ring, 7'(m)}, 8'h00, "wake");
		rdr(CDGC_OFF_CHANGE);
		repeat (3) @(posedge clk);
		#1 chk({7'h0, ring}, 8'h01, "ring up");
		wr(CDGC_OFF_DETECT, 8'h02);
		@(posedge clk) ins <= 1'b1;
		repeat (4) @(posedge clk) ins <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk(8'(m), 8'h01, "removal");
		$display("wake done");
		wr(CDGC_OFF_GLOBAL, 8'h09);
		repeat (2) @(posedge clk);
		#1 chk({7'h0, oe}, 8'h00, "sleep");
		@(posedge clk) act <= 1'b1;
		@(posedge clk) act <= 1'b0;
		#1 chk({7'h0, oe}, 8'h01, "access");
		@(posedge clk) irq <= 1'b1;
		#1 chk({7'h0, oe}, 8'h00, "float");
		repeat (4) @(posedge clk);
		#1 chk({7'h0, fo}, 8'h01, "level");
		$display("sleep done");
		wr(CDGC_OFF_GLOBAL, 8'h06);
		rdr(CDGC_OFF_CHANGE);
		chk(v, 8'h01, "wr mode");
		rdr(CDGC_OFF_CHANGE);
		chk({6'h0, v[0], chg}, 8'h03, "no rd clear");
		wr(CDGC_OFF_CHANGE, 8'h01);
		rdr(CDGC_OFF_CHANGE);
		chk({6'h0, v[0], chg}, 8'h00, "wr clear");
		$display("clear done");
		print_verdict();
	end
endmodule : card_detect_global_control_tb
`default_nettype wire
